// ==== pps_defs.svh ====
// Constants for the power path source selector: codes, field positions, resets
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH

// ----------------------------------------------------------------------
// Flag bundle and synchroniser
// ----------------------------------------------------------------------
`define PPS_FLAG_W      9
`define PPS_SYNC_STAGES 2

// ----------------------------------------------------------------------
// Input current limit codes
// ----------------------------------------------------------------------
`define PPS_ILIM_100MA  2'h0
`define PPS_ILIM_500MA  2'h1
`define PPS_ILIM_2750MA 2'h2

// ----------------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------------
`define PPS_ST_AC_SEL   0
`define PPS_ST_USB_SEL  1
`define PPS_ST_BAT_ON   2
`define PPS_ST_AC_OVP   3
`define PPS_ST_USB_OVP  4
`define PPS_ST_SUPPLY   5
`define PPS_ST_IN_SHORT 6
`define PPS_ST_BAT_SHRT 7
`define PPS_STATUS_W    8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PPS_STATUS_RST  8'h04
`define PPS_USB_ILIM_RST `PPS_ILIM_500MA

`endif

// ==== pps_pkg.sv ====
// Types shared by the power path source selector files
package pps_pkg;

    // Comparator flags, most significant field first
    typedef struct packed {
        logic ac_detect;
        logic usb_detect;
        logic ac_overvoltage;
        logic usb_overvoltage;
        logic input_short;
        logic battery_short;
        logic supplement_need;
        logic droop_low;
        logic thermal_shutdown;
    } pps_flags_t;

    // Host configuration bits
    typedef struct packed {
        logic override_bit;
        logic charge_on;
        logic limit_high_select;
        logic usb_limit_mid_select;
    } pps_config_t;

    // Source currently driving the system bus
    typedef enum logic [1:0] {
        PPS_ST_BAT,
        PPS_ST_AC,
        PPS_ST_USB,
        PPS_ST_GAP
    } pps_state_t;

endpackage

// ==== pps_sync.sv ====
// Two-flop level synchroniser for a bundle of comparator flags
`timescale 1ns/1ps
`include "pps_defs.svh"

module pps_sync #(
    parameter int WIDTH = `PPS_FLAG_W
) (
    // Clock, reset, enable
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic             ce,
    // Flags
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // ------------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------------
    // First stage feeds only the second stage
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            meta     <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// ==== pps_power_path.sv ====
// Power path source selector: switch enables, USB limit and status
`timescale 1ns/1ps
`include "pps_defs.svh"

// How it works
// - With override high the bus source is adapter, then USB, then battery.
// - With override low both input switches are off and the battery is on.
// - Override high and adapter present enables adapter, never USB.
// - No input detected turns both input switches off and battery on.
// - Battery switch turns on for charging when an input feeds, charging is on and no battery short is seen.
// - While an input feeds with charging off and no battery short, battery switch follows the supplement-need flag.
// - Losing the selected input moves to the next present source in order.
// - Battery override never reconnects an input when the battery is removed.
// - USB limit is 100 mA, 500 mA or 2.75 A from the two select bits.
// - The adapter limit is fixed and ignores the select bits.
// - Battery short is ignored while the droop loop is below 1 V.
// - Power path state is shown in the charger status register.
// - After reset config applies at once, charge is off, limit is 500 mA.
// - Input overvoltage only sets a status bit, switches are untouched.
// - Thermal shutdown turns input switches off and battery on.
// - Input short turns input switches off until the flag clears.

module pps_power_path (
    // Clock, reset, enable
    input  wire logic                      mclk,
    input  wire logic                      resetn,
    input  wire logic                      ce,
    // Comparator flags from the analog side
    input  wire pps_pkg::pps_flags_t       flags_async,
    // Host configuration bits from the charger config register
    input  wire pps_pkg::pps_config_t      charger_config_register,
    // Switch enables
    output logic                           ac_sw_en,
    output logic                           usb_sw_en,
    output logic                           bat_sw_en,
    output logic                           charge_en,
    // Input current limits
    output logic [1:0]                     usb_limit,
    output logic [1:0]                     ac_limit,
    // Status
    output logic [`PPS_STATUS_W-1:0]       charger_status_register
);

    pps_pkg::pps_flags_t   flags;
    pps_pkg::pps_state_t   state;
    pps_pkg::pps_state_t   next_state;
    pps_pkg::pps_state_t   target;
    logic                  bat_short_q;
    logic                  next_ac_sw_en;
    logic                  next_usb_sw_en;
    logic                  next_bat_sw_en;
    logic                  next_charge_en;
    logic [1:0]            next_usb_limit;
    logic [`PPS_STATUS_W-1:0] next_status;

    // ------------------------------------------------------------------
    // Flag synchroniser
    // ------------------------------------------------------------------
    // Comparators run on no clock, so every flag crosses two flops
    pps_sync #(
        .WIDTH    (`PPS_FLAG_W)
    ) u_sync (
        .mclk     (mclk),
        .resetn   (resetn),
        .ce       (ce),
        .async_in (flags_async),
        .sync_out (flags)
    );

    // Limit decode shared by the next-value logic
    function automatic logic [1:0] usb_limit_code(input logic hi,
                                                  input logic mid);
        if (hi)
            usb_limit_code = `PPS_ILIM_2750MA;
        else if (mid)
            usb_limit_code = `PPS_ILIM_500MA;
        else
            usb_limit_code = `PPS_ILIM_100MA;
    endfunction

    // ------------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------------
    // Target source from priority, override and faults
    always_comb begin
        bat_short_q = flags.battery_short & ~flags.droop_low;
        if (!charger_config_register.override_bit)
            target = pps_pkg::PPS_ST_BAT;
        else if (flags.thermal_shutdown)
            target = pps_pkg::PPS_ST_BAT;
        else if (flags.input_short)
            target = pps_pkg::PPS_ST_BAT;
        else if (flags.ac_detect)
            target = pps_pkg::PPS_ST_AC;
        else if (flags.usb_detect)
            target = pps_pkg::PPS_ST_USB;
        else
            target = pps_pkg::PPS_ST_BAT;
    end

    // Next state: an input-to-input swap passes one gap cycle so the
    // two input switches are never on together
    always_comb begin
        next_state = target;
        case (state)
            pps_pkg::PPS_ST_AC: begin
                if (target == pps_pkg::PPS_ST_USB)
                    next_state = pps_pkg::PPS_ST_GAP;
            end
            pps_pkg::PPS_ST_USB: begin
                if (target == pps_pkg::PPS_ST_AC)
                    next_state = pps_pkg::PPS_ST_GAP;
            end
            pps_pkg::PPS_ST_BAT: next_state = target;
            pps_pkg::PPS_ST_GAP: next_state = target;
            default: next_state = pps_pkg::PPS_ST_BAT;
        endcase
    end

    // ------------------------------------------------------------------
    // Output next values
    // ------------------------------------------------------------------
    always_comb begin
        next_ac_sw_en  = (next_state == pps_pkg::PPS_ST_AC);
        next_usb_sw_en = (next_state == pps_pkg::PPS_ST_USB);
        next_charge_en = charger_config_register.override_bit &
                         charger_config_register.charge_on &
                         (next_ac_sw_en | next_usb_sw_en) &
                         ~bat_short_q;
        if (next_ac_sw_en || next_usb_sw_en)
            // Battery short opens the switch only while an input feeds
            next_bat_sw_en = (next_charge_en | flags.supplement_need) &
                             ~bat_short_q;
        else
            next_bat_sw_en = 1'b1;
        next_usb_limit = usb_limit_code(
            charger_config_register.limit_high_select,
            charger_config_register.usb_limit_mid_select);
        next_status = '0;
        next_status[`PPS_ST_AC_SEL]   = next_ac_sw_en;
        next_status[`PPS_ST_USB_SEL]  = next_usb_sw_en;
        next_status[`PPS_ST_BAT_ON]   = next_bat_sw_en;
        next_status[`PPS_ST_AC_OVP]   = flags.ac_overvoltage;
        next_status[`PPS_ST_USB_OVP]  = flags.usb_overvoltage;
        next_status[`PPS_ST_SUPPLY]   = flags.supplement_need;
        next_status[`PPS_ST_IN_SHORT] = flags.input_short;
        next_status[`PPS_ST_BAT_SHRT] = bat_short_q;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Reset leaves the bus on battery, charging off, USB at 500 mA
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state                   <= pps_pkg::PPS_ST_BAT;
            ac_sw_en                <= 1'b0;
            usb_sw_en               <= 1'b0;
            bat_sw_en               <= 1'b1;
            charge_en               <= 1'b0;
            usb_limit               <= `PPS_USB_ILIM_RST;
            ac_limit                <= `PPS_ILIM_2750MA;
            charger_status_register <= `PPS_STATUS_RST;
        end else if (ce) begin
            state                   <= next_state;
            ac_sw_en                <= next_ac_sw_en;
            usb_sw_en               <= next_usb_sw_en;
            bat_sw_en               <= next_bat_sw_en;
            charge_en               <= next_charge_en;
            usb_limit               <= next_usb_limit;
            ac_limit                <= `PPS_ILIM_2750MA;
            charger_status_register <= next_status;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_inputs_off;
        !ac_sw_en && !usb_sw_en && bat_sw_en;
    endsequence

    sequence s_ac_only;
        ac_sw_en && !usb_sw_en;
    endsequence

    AST_OVERRIDE_LOW: assert property (@(posedge mclk)
        disable iff (!resetn || !ce)
        !charger_config_register.override_bit |=> s_inputs_off)
        else $error("override low did not force battery only");

    AST_AC_FIRST: assert property (@(posedge mclk)
        disable iff (!resetn || !ce)
        (charger_config_register.override_bit && flags.ac_detect &&
         !flags.thermal_shutdown && !flags.input_short)[*2]
        |=> s_ac_only)
        else $error("adapter present but not selected alone");

    AST_NO_INPUT: assert property (@(posedge mclk)
        disable iff (!resetn || !ce)
        (!flags.ac_detect && !flags.usb_detect) |=> s_inputs_off)
        else $error("no input yet an input switch is on");

    AST_USB_SECOND: assert property (@(posedge mclk)
        disable iff (!resetn || !ce)
        (charger_config_register.override_bit && !flags.ac_detect &&
         flags.usb_detect && !flags.thermal_shutdown &&
         !flags.input_short) |-> ##[1:2] (usb_sw_en && !ac_sw_en))
        else $error("USB not selected after adapter loss");

    AST_USB_LIMIT: assert property (@(posedge mclk)
        disable iff (!resetn || !ce)
        1'b1 |=> usb_limit == usb_limit_code(
            $past(charger_config_register.limit_high_select),
            $past(charger_config_register.usb_limit_mid_select)))
        else $error("USB limit does not follow select bits");

    AST_AC_LIMIT: assert property (@(posedge mclk)
        disable iff (!resetn)
        ac_limit == `PPS_ILIM_2750MA)
        else $error("adapter limit changed");

    AST_THERMAL: assert property (@(posedge mclk)
        disable iff (!resetn || !ce)
        flags.thermal_shutdown |=> s_inputs_off)
        else $error("thermal shutdown left an input on");

    AST_IN_SHORT: assert property (@(posedge mclk)
        disable iff (!resetn || !ce)
        flags.input_short |=> (!ac_sw_en && !usb_sw_en))
        else $error("input short left an input on");

    AST_NO_OVERLAP: assert property (@(posedge mclk)
        disable iff (!resetn)
        !(ac_sw_en && usb_sw_en))
        else $error("both input switches on");

    AST_OVP_STATUS: assert property (@(posedge mclk)
        disable iff (!resetn || !ce)
        $rose(flags.usb_overvoltage) && $stable(state) |=>
        charger_status_register[`PPS_ST_USB_OVP] &&
        $stable(usb_sw_en))
        else $error("overvoltage did not only set status");

    AST_STATUS_SEL: assert property (@(posedge mclk)
        disable iff (!resetn)
        charger_status_register[`PPS_ST_AC_SEL] == ac_sw_en &&
        charger_status_register[`PPS_ST_USB_SEL] == usb_sw_en &&
        charger_status_register[`PPS_ST_BAT_ON] == bat_sw_en)
        else $error("status does not mirror switches");

    AST_SUPPLEMENT: assert property (@(posedge mclk)
        disable iff (!resetn || !ce)
        (charger_config_register.override_bit &&
         !charger_config_register.charge_on && flags.ac_detect &&
         !flags.thermal_shutdown && !flags.input_short &&
         !bat_short_q)[*2] |=>
        bat_sw_en == $past(flags.supplement_need))
        else $error("battery switch ignores supplement need");

endmodule

// ==== pps_analog_model.sv ====
// Behavioural model of the comparators and host bits around the selector
`timescale 1ns/1ps

module pps_analog_model (
    // Clock
    input  wire logic            mclk,
    // Switch enables from the selector
    input  wire logic            ac_sw_en,
    input  wire logic            usb_sw_en,
    // Comparator flags and host bits
    output pps_pkg::pps_flags_t  flags_async,
    output pps_pkg::pps_config_t cfg
);
    int overlap_cnt;

    // -------------------------------------------------------------
    // Flag and host bit driver
    // -------------------------------------------------------------
    // Everything starts quiet: no input, battery only
    initial begin
        flags_async = '0;
        cfg = '0;
        overlap_cnt = 0;
    end

    // Changes land off the sampling edge, like a slow comparator
    task automatic apply(input pps_pkg::pps_flags_t f,
                         input pps_pkg::pps_config_t c);
        @(negedge mclk);
        flags_async = f;
        cfg = c;
    endtask

    // Two inputs on the bus together would back-feed one supply
    always @(posedge mclk) begin
        if (ac_sw_en === 1'b1 && usb_sw_en === 1'b1) begin
            overlap_cnt <= overlap_cnt + 1;
        end
    end
endmodule

// ==== pps_power_path_test.sv ====
// Self-checking bench for the power path source selector
`timescale 1ns/1ps
`include "pps_defs.svh"

module pps_power_path_test;
    logic                 mclk;
    logic                 resetn;
    logic                 ce;
    logic                 ac_sw_en;
    logic                 usb_sw_en;
    logic                 bat_sw_en;
    logic                 charge_en;
    logic [1:0]           usb_limit;
    logic [1:0]           ac_limit;
    logic [7:0]           charger_status_register;
    pps_pkg::pps_flags_t  flags_async;
    pps_pkg::pps_config_t cfg;
    pps_pkg::pps_flags_t  f;
    pps_pkg::pps_config_t c;
    int                   error_cnt;
    int                   check_count;

    pps_power_path i_pps_power_path (
        .mclk                    (mclk),
        .resetn                  (resetn),
        .ce                      (ce),
        .flags_async             (flags_async),
        .charger_config_register (cfg),
        .ac_sw_en                (ac_sw_en),
        .usb_sw_en               (usb_sw_en),
        .bat_sw_en               (bat_sw_en),
        .charge_en               (charge_en),
        .usb_limit               (usb_limit),
        .ac_limit                (ac_limit),
        .charger_status_register (charger_status_register)
    );

    pps_analog_model i_pps_analog_model (
        .mclk        (mclk),
        .ac_sw_en    (ac_sw_en),
        .usb_sw_en   (usb_sw_en),
        .flags_async (flags_async),
        .cfg         (cfg)
    );

    // -------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Switches packed as ac, usb, battery in the low three bits
    task automatic sw(input logic [7:0] exp);
        check("switches", {5'h00, ac_sw_en, usb_sw_en, bat_sw_en}, exp);
    endtask

    // Six edges cover sync, output and the swap gap with margin
    task automatic step();
        i_pps_analog_model.apply(f, c);
        repeat (6) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic test_reset();
        sw(8'h01);
        check("charge_en", {7'h00, charge_en}, 8'h00);
        check("usb_limit", {6'h00, usb_limit}, 8'h01);
        check("status", charger_status_register, 8'h04);
        $display("test_reset done");
    endtask

    task automatic test_limits();
        for (int i = 0; i < 4; i++) begin
            c.limit_high_select = i[1];
            c.usb_limit_mid_select = i[0];
            i_pps_analog_model.apply(f, c);
            @(negedge mclk);
            check("usb_limit", {6'h00, usb_limit},
                  i[1] ? 8'h02 : {7'h00, i[0]});
            check("ac_limit", {6'h00, ac_limit}, 8'h02);
        end
        // A frozen block must hold its limit while the bits move
        ce = 1'b0;
        c = '0;
        i_pps_analog_model.apply(f, c);
        repeat (3) @(negedge mclk);
        check("usb_limit_frozen", {6'h00, usb_limit}, 8'h02);
        ce = 1'b1;
        @(negedge mclk);
        check("usb_limit_run", {6'h00, usb_limit}, 8'h00);
        $display("test_limits done");
    endtask

    task automatic test_priority();
        c.override_bit = 1'b1;
        f.ac_detect = 1'b1;
        f.usb_detect = 1'b1;
        step();
        sw(8'h04);
        check("st_ac", {7'h00, charger_status_register[`PPS_ST_AC_SEL]},
              8'h01);
        f.supplement_need = 1'b1;
        step();
        sw(8'h05);
        f.supplement_need = 1'b0;
        c.charge_on = 1'b1;
        step();
        sw(8'h05);
        check("charge_en", {7'h00, charge_en}, 8'h01);
        f.ac_detect = 1'b0;
        step();
        sw(8'h03);
        check("st_usb", {7'h00, charger_status_register[`PPS_ST_USB_SEL]},
              8'h01);
        check("overlap", i_pps_analog_model.overlap_cnt[7:0], 8'h00);
        f.usb_detect = 1'b0;
        step();
        sw(8'h01);
        check("charge_off", {7'h00, charge_en}, 8'h00);
        $display("test_priority done");
    endtask

    task automatic test_override_low();
        f.ac_detect = 1'b1;
        f.usb_detect = 1'b1;
        c.override_bit = 1'b0;
        step();
        sw(8'h01);
        check("charge_en", {7'h00, charge_en}, 8'h00);
        $display("test_override_low done");
    endtask

    task automatic test_faults();
        c = 4'h8;
        f = '0;
        f.ac_detect = 1'b1;
        step();
        // Both inputs flag overvoltage; the bus must stay on the adapter
        f.ac_overvoltage = 1'b1;
        f.usb_overvoltage = 1'b1;
        step();
        sw(8'h04);
        check("st_ovp", {7'h00, charger_status_register[`PPS_ST_AC_OVP]},
              8'h01);
        check("st_usb_ovp", {7'h00, charger_status_register[`PPS_ST_USB_OVP]},
              8'h01);
        f.ac_overvoltage = 1'b0;
        f.usb_overvoltage = 1'b0;
        f.thermal_shutdown = 1'b1;
        step();
        sw(8'h01);
        f.thermal_shutdown = 1'b0;
        f.input_short = 1'b1;
        step();
        sw(8'h01);
        check("status", charger_status_register, 8'h44);
        f.input_short = 1'b0;
        step();
        sw(8'h04);
        f.supplement_need = 1'b1;
        f.battery_short = 1'b1;
        f.droop_low = 1'b1;
        step();
        sw(8'h05);
        check("status", charger_status_register, 8'h25);
        f.droop_low = 1'b0;
        step();
        sw(8'h04);
        check("st_bshort", {7'h00, charger_status_register[`PPS_ST_BAT_SHRT]},
              8'h01);
        $display("test_faults done");
    endtask

    // -------------------------------------------------------------
    // Clock, watchdog and main sequence
    // -------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // The run needs about 115 cycles; this leaves wide margin
    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        finish_test();
    end

    initial begin
        error_cnt = 0;
        check_count = 0;
        resetn = 1'b0;
        ce = 1'b1;
        f = '0;
        c = '0;
        repeat (10) @(negedge mclk);
        test_reset();
        resetn = 1'b1;
        test_limits();
        test_priority();
        test_override_low();
        test_faults();
        finish_test();
    end
endmodule
